// *** src/compare_skip_branch_exec.sv ***
`timescale 1ns/10ps
// ********************
// Compare, skip and flag branch execution
// ********************
module compare_skip_branch_exec (
	input  wire logic                              clk,               // Core clock
	input  wire logic                              rst,               // Async reset
	input  wire logic                              issue,             // Instruction valid pulse
	input  wire cmp_skip_pkg::op_t                 op,                // Decoded operation
	input  wire logic                              branch_on_flag_set_op, // Flag branch
	input  wire logic [cmp_skip_pkg::DATA_W-1:0]   dest_value,        // Destination register
	input  wire logic [cmp_skip_pkg::DATA_W-1:0]   source_operand,    // Source register
	input  wire logic [cmp_skip_pkg::DATA_W-1:0]   immediate,         // Encoded constant
	input  wire logic [2:0]                        bit_select,        // Tested bit or flag
	input  wire logic [cmp_skip_pkg::DATA_W-1:0]   io_value,          // Addressed I/O byte
	input  wire logic [cmp_skip_pkg::OFS_W-1:0]    offset,            // Signed branch offset
	input  wire logic                              next_is_long,      // Following op two words
	output logic                                   busy,              // Extra cycles running
	output logic                                   flag_write,        // Flags updated pulse
	output logic [cmp_skip_pkg::DATA_W-1:0]        flag_register,     // Status flags
	output logic [cmp_skip_pkg::PTR_W-1:0]         instruction_pointer // Program pointer
);
	logic       zf, nf, vf, cf, hf;    // Subtractor flags
	logic [cmp_skip_pkg::DATA_W-1:0] sub_b; // Subtrahend choice
	logic       sub_cin;               // Carry into subtract
	logic       is_cmp;                // Compare class
	logic       take;                  // Skip or branch taken
	logic [cmp_skip_pkg::PTR_W-1:0] next_ptr; // Next pointer
	logic [1:0] next_extra;            // Stall cycles to add
	logic [1:0] extra;                 // Stall counter
	logic [cmp_skip_pkg::PTR_W-1:0] ofs_ext; // Sign-extended offset
	logic       accept;                // Instruction accepted

	// ********************
	// Handshake
	// ********************
	// Issue is ignored while a stall runs
	assign accept = issue & ~busy;
	// Busy while the stall counter is not empty
	assign busy   = (extra != cmp_skip_pkg::EXTRA_NONE);

	// ********************
	// Compare datapath
	// ********************
	// Operand choice per compare kind
	always_comb
	begin
		is_cmp  = (op == cmp_skip_pkg::op_compare) || (op == cmp_skip_pkg::op_compare_carry)
			|| (op == cmp_skip_pkg::op_compare_immediate);
		sub_b   = (op == cmp_skip_pkg::op_compare_immediate) ? immediate : source_operand;
		sub_cin = (op == cmp_skip_pkg::op_compare_carry) & flag_register[cmp_skip_pkg::FLAG_C];
	end

	// Shared subtractor
	flag_subtract #(.W(cmp_skip_pkg::DATA_W)) u_sub (
		.minuend    (dest_value),
		.subtrahend (sub_b),
		.borrow_in  (sub_cin),
		.zero       (zf),
		.negative   (nf),
		.overflow   (vf),
		.carry      (cf),
		.half       (hf)
	);

	// Flag register updates, result discarded
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			flag_register <= cmp_skip_pkg::FLAGS_RESET;
			flag_write    <= 1'b0;
		end
		else
		begin
			// One-cycle pulse on each compare
			flag_write <= accept & is_cmp & ~branch_on_flag_set_op;
			if (accept & is_cmp & ~branch_on_flag_set_op)
			begin
				flag_register[cmp_skip_pkg::FLAG_Z] <= zf;
				flag_register[cmp_skip_pkg::FLAG_N] <= nf;
				flag_register[cmp_skip_pkg::FLAG_V] <= vf;
				flag_register[cmp_skip_pkg::FLAG_C] <= cf;
				flag_register[cmp_skip_pkg::FLAG_H] <= hf;
				flag_register[cmp_skip_pkg::FLAG_S] <= nf ^ vf;
			end
		end
	end

	// ********************
	// Skip and branch decision
	// ********************
	always_comb
	begin
		// Defaults: next word, no stall
		ofs_ext    = {{(cmp_skip_pkg::PTR_W-cmp_skip_pkg::OFS_W){offset[cmp_skip_pkg::OFS_W-1]}}, offset};
		take       = 1'b0;
		next_ptr   = instruction_pointer + cmp_skip_pkg::STEP_ONE;
		next_extra = cmp_skip_pkg::EXTRA_NONE;
		if (branch_on_flag_set_op)
		begin
			take = flag_register[bit_select];
			if (take)
			begin
				next_ptr   = instruction_pointer + ofs_ext + cmp_skip_pkg::STEP_ONE;
				// One stall cycle for a taken branch
				next_extra = cmp_skip_pkg::EXTRA_ONE;
			end
		end
		else
		begin
			// Bit under test per skip kind
			unique case (op)
				cmp_skip_pkg::op_skip_reg_bit_clear: take = ~source_operand[bit_select];
				cmp_skip_pkg::op_skip_reg_bit_set:   take = source_operand[bit_select];
				cmp_skip_pkg::op_skip_io_bit_clear:  take = ~io_value[bit_select];
				cmp_skip_pkg::op_skip_io_bit_set:    take = io_value[bit_select];
				default:                             take = 1'b0;
			endcase
			if (take)
			begin
				next_ptr   = instruction_pointer + (next_is_long ? cmp_skip_pkg::STEP_LONG
					: cmp_skip_pkg::STEP_SHORT);
				// Stall covers the skipped words
				next_extra = next_is_long ? cmp_skip_pkg::EXTRA_TWO : cmp_skip_pkg::EXTRA_ONE;
			end
		end
	end

	// Pointer advance; sequential when not taken
	always_ff @(posedge clk or posedge rst)
	begin
		// Moves only on an accepted op
		if (rst)
			instruction_pointer <= cmp_skip_pkg::PTR_RESET;
		else if (accept)
			instruction_pointer <= next_ptr;
	end

	// Stall counter for taken skips and branches
	always_ff @(posedge clk or posedge rst)
	begin
		// Load on accept, then count down
		if (rst)
			extra <= cmp_skip_pkg::EXTRA_NONE;
		else if (accept)
			extra <= next_extra;
		else if (busy)
			extra <= extra - 2'h1;
	end

	// ********************
	// Checks
	// ********************
	cmp_one_cycle_a: assert property (@(posedge clk) disable iff (rst)
		accept && op == cmp_skip_pkg::op_compare && !branch_on_flag_set_op
		|=> flag_register[cmp_skip_pkg::FLAG_Z] == (($past(dest_value) - $past(source_operand)) == 8'h00)
		&& !busy) else $error("compare flag or timing wrong");
	cmp_carry_a: assert property (@(posedge clk) disable iff (rst)
		accept && op == cmp_skip_pkg::op_compare_carry && !branch_on_flag_set_op && dest_value == source_operand
		&& flag_register[cmp_skip_pkg::FLAG_C] |=> flag_register[cmp_skip_pkg::FLAG_C])
		else $error("compare carry borrow lost");
	cmp_imm_a: assert property (@(posedge clk) disable iff (rst)
		accept && op == cmp_skip_pkg::op_compare_immediate && !branch_on_flag_set_op && dest_value == immediate
		|=> flag_register[cmp_skip_pkg::FLAG_Z] && flag_write) else $error("compare immediate wrong");

	// ********************
	// Skip and branch checks
	// ********************
	skip_reg_clr_a: assert property (@(posedge clk) disable iff (rst)
		accept && !branch_on_flag_set_op && op == cmp_skip_pkg::op_skip_reg_bit_clear
		&& !source_operand[bit_select] && !next_is_long
		|=> instruction_pointer == $past(instruction_pointer) + 16'h0002 && $stable(flag_register))
		else $error("register clear skip wrong");
	skip_reg_set_a: assert property (@(posedge clk) disable iff (rst)
		accept && !branch_on_flag_set_op && op == cmp_skip_pkg::op_skip_reg_bit_set
		&& source_operand[bit_select] && next_is_long |=> busy ##1 busy ##1 !busy)
		else $error("register set skip timing wrong");
	skip_io_clr_a: assert property (@(posedge clk) disable iff (rst)
		accept && !branch_on_flag_set_op && op == cmp_skip_pkg::op_skip_io_bit_clear && !io_value[bit_select]
		|=> instruction_pointer == $past(instruction_pointer) + ($past(next_is_long) ? 16'h0003 : 16'h0002))
		else $error("I/O clear skip wrong");
	skip_io_set_a: assert property (@(posedge clk) disable iff (rst)
		accept && !branch_on_flag_set_op && op == cmp_skip_pkg::op_skip_io_bit_set && io_value[bit_select]
		&& next_is_long |=> instruction_pointer == $past(instruction_pointer) + 16'h0003)
		else $error("I/O set skip wrong");
	branch_taken_a: assert property (@(posedge clk) disable iff (rst)
		accept && branch_on_flag_set_op && flag_register[bit_select]
		|=> instruction_pointer == $past(instruction_pointer) + $past(ofs_ext) + 16'h0001 && busy)
		else $error("flag branch target wrong");
	not_taken_a: assert property (@(posedge clk) disable iff (rst)
		accept && !take |=> instruction_pointer == $past(instruction_pointer) + 16'h0001 && !busy)
		else $error("not-taken path wrong");

	// ********************
	// Compare result checks
	// ********************
	cmp_borrow_a: assert property (@(posedge clk) disable iff (rst)
		accept && op == cmp_skip_pkg::op_compare && !branch_on_flag_set_op
		|=> flag_register[cmp_skip_pkg::FLAG_C] == ($past(dest_value) < $past(source_operand)))
		else $error("compare borrow wrong");
	carry_equal_a: assert property (@(posedge clk) disable iff (rst)
		accept && op == cmp_skip_pkg::op_compare_carry && !branch_on_flag_set_op && dest_value == source_operand
		&& !flag_register[cmp_skip_pkg::FLAG_C]
		|=> flag_register[cmp_skip_pkg::FLAG_Z] && !flag_register[cmp_skip_pkg::FLAG_C])
		else $error("compare carry equal case wrong");
	imm_borrow_a: assert property (@(posedge clk) disable iff (rst)
		accept && op == cmp_skip_pkg::op_compare_immediate && !branch_on_flag_set_op
		|=> flag_register[cmp_skip_pkg::FLAG_C] == ($past(dest_value) < $past(immediate)) && flag_write)
		else $error("compare immediate borrow wrong");

	// ********************
	// Stall, refusal and flag hold checks
	// ********************
	io_skip_flags_a: assert property (@(posedge clk) disable iff (rst)
		accept && !branch_on_flag_set_op
		&& (op == cmp_skip_pkg::op_skip_io_bit_clear || op == cmp_skip_pkg::op_skip_io_bit_set)
		|=> $stable(flag_register) && !flag_write) else $error("I/O skip touched flags");
	branch_stall_a: assert property (@(posedge clk) disable iff (rst)
		accept && branch_on_flag_set_op && flag_register[bit_select]
		|=> busy && $stable(flag_register) ##1 !busy) else $error("flag branch stall wrong");
	skip_short_stall_a: assert property (@(posedge clk) disable iff (rst)
		accept && !branch_on_flag_set_op && take && !next_is_long |=> busy ##1 !busy)
		else $error("short skip stall wrong");
	refused_busy_a: assert property (@(posedge clk) disable iff (rst)
		busy |=> $stable(instruction_pointer) && $stable(flag_register) && !flag_write)
		else $error("issue accepted while stalled");
	reg_skip_miss_a: assert property (@(posedge clk) disable iff (rst)
		accept && !branch_on_flag_set_op && op == cmp_skip_pkg::op_skip_reg_bit_clear && source_operand[bit_select]
		|=> instruction_pointer == $past(instruction_pointer) + 16'h0001 && !busy)
		else $error("untaken register skip wrong");
endmodule : compare_skip_branch_exec

// *** src/cmp_skip_pkg.sv ***
package cmp_skip_pkg;

	// ********************
	// Widths
	// ********************
	localparam int DATA_W   = 8;   // Register width
	localparam int PTR_W    = 16;  // Instruction pointer width
	localparam int OFS_W    = 7;   // Branch offset width
	localparam int IO_AW    = 5;   // Bit-addressable I/O address width
	localparam int REG_AW   = 5;   // General register index width

	// ********************
	// Flag positions
	// ********************
	localparam int FLAG_C = 0;  // Carry
	localparam int FLAG_Z = 1;  // Zero
	localparam int FLAG_N = 2;  // Negative
	localparam int FLAG_V = 3;  // Overflow
	localparam int FLAG_S = 4;  // Sign
	localparam int FLAG_H = 5;  // Half carry

	// ********************
	// Reset values and step sizes
	// ********************
	localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;    // Flags after reset
	localparam logic [PTR_W-1:0]  PTR_RESET   = 16'h0000; // Pointer after reset
	localparam logic [PTR_W-1:0]  STEP_ONE    = 16'h0001; // Next instruction
	localparam logic [PTR_W-1:0]  STEP_SHORT  = 16'h0002; // Skip one-word op
	localparam logic [PTR_W-1:0]  STEP_LONG   = 16'h0003; // Skip two-word op
	localparam logic [1:0]        EXTRA_NONE  = 2'h0;     // No extra cycles
	localparam logic [1:0]        EXTRA_ONE   = 2'h1;     // One stall cycle
	localparam logic [1:0]        EXTRA_TWO   = 2'h2;     // Two stall cycles

	// Operation codes from decode
	typedef enum logic [2:0] {
		op_none,
		op_compare,
		op_compare_carry,
		op_compare_immediate,
		op_skip_reg_bit_clear,
		op_skip_reg_bit_set,
		op_skip_io_bit_clear,
		op_skip_io_bit_set
	} op_t;

endpackage : cmp_skip_pkg

// *** src/flag_subtract.sv ***
`timescale 1ns/10ps
// ********************
// Subtract with flag generation
// ********************
module flag_subtract #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] minuend,      // Destination value
	input  wire logic [W-1:0] subtrahend,   // Source or constant
	input  wire logic         borrow_in,    // Carry in
	output logic              zero,         // Z result
	output logic              negative,     // N result
	output logic              overflow,     // V result
	output logic              carry,        // C result
	output logic              half          // H result
);
	logic [W-1:0] diff; // Discarded difference

	// Difference and flag terms
	always_comb
	begin
		diff     = minuend - subtrahend - {{(W-1){1'b0}}, borrow_in};
		zero     = (diff == '0);
		negative = diff[W-1];
		overflow = (minuend[W-1] & ~subtrahend[W-1] & ~diff[W-1])
			| (~minuend[W-1] & subtrahend[W-1] & diff[W-1]);
		carry    = (~minuend[W-1] & subtrahend[W-1]) | (subtrahend[W-1] & diff[W-1])
			| (diff[W-1] & ~minuend[W-1]);
		half     = (~minuend[3] & subtrahend[3]) | (subtrahend[3] & diff[3])
			| (diff[3] & ~minuend[3]);
	end
endmodule : flag_subtract

// *** verif/test_compare_skip_branch_exec.sv ***
`timescale 1ns/10ps
module test_compare_skip_branch_exec;
	// ********************
	// Stimulus, outputs and bookkeeping
	// ********************
	logic                 clk = 1'b0;  // Core clock
	logic                 rst = 1'b1;  // Async reset
	logic                 issue = 1'b0; // Instruction valid
	cmp_skip_pkg::op_t    op = cmp_skip_pkg::op_none; // Decoded op
	logic                 br = 1'b0;   // Flag branch select
	logic [7:0]           dest = 8'h00, src = 8'h00, imm = 8'h00, io = 8'h00; // Operands
	logic [2:0]           bsel = 3'h0; // Tested bit
	logic [6:0]           ofs = 7'h00; // Branch offset
	logic                 nlong = 1'b0; // Next op two words
	logic                 busy, flag_write; // Design outputs
	logic [7:0]           flag_register; // Design flags
	logic [15:0]          instruction_pointer; // Design pointer
	int                   failures = 0, comparisons = 0; // Counters
	logic [15:0]          seed = 16'h001E; // Random state
	logic [7:0]           mflags; // Model flags
	logic [15:0]          mptr;   // Model pointer
	int                   mbusy;  // Model stall cycles left
	logic                 mwrite; // Model flag write pulse

	compare_skip_branch_exec compare_skip_branch_exec_inst (.clk(clk), .rst(rst), .issue(issue), .op(op),
		.branch_on_flag_set_op(br), .dest_value(dest), .source_operand(src), .immediate(imm),
		.bit_select(bsel), .io_value(io), .offset(ofs), .next_is_long(nlong), .busy(busy),
		.flag_write(flag_write), .flag_register(flag_register), .instruction_pointer(instruction_pointer));

	// Free running clock
	always #4 clk = ~clk;

	// Maximal length shift register step
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	// Verdict and end of run
	task automatic tally_and_finish;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	// Model of one clock edge from the driven inputs
	task automatic apply;
		logic [8:0] r;
		logic [7:0] s;
		logic       c;
		logic       take;
		mwrite = 1'b0;
		if (mbusy != 0)
			mbusy--;
		else if (issue)
		begin
			if (br)
			begin
				take = mflags[bsel];
				mptr = mptr + (take ? {{9{ofs[6]}}, ofs} + 16'h0001 : 16'h0001);
				mbusy = take ? 1 : 0;
			end
			else if (op == cmp_skip_pkg::op_compare || op == cmp_skip_pkg::op_compare_carry ||
				op == cmp_skip_pkg::op_compare_immediate)
			begin
				s = (op == cmp_skip_pkg::op_compare_immediate) ? imm : src;
				c = (op == cmp_skip_pkg::op_compare_carry) ? mflags[0] : 1'b0;
				r = {1'b0, dest} - {1'b0, s} - {8'h00, c};
				mflags[0] = r[8];
				mflags[1] = (r[7:0] == 8'h00);
				mflags[2] = r[7];
				mflags[3] = (dest[7] & ~s[7] & ~r[7]) | (~dest[7] & s[7] & r[7]);
				mflags[4] = mflags[2] ^ mflags[3];
				mflags[5] = (~dest[3] & s[3]) | (s[3] & r[3]) | (r[3] & ~dest[3]);
				mwrite = 1'b1;
				mptr = mptr + 16'h0001;
			end
			else if (op != cmp_skip_pkg::op_none)
			begin
				c = (op == cmp_skip_pkg::op_skip_reg_bit_clear || op == cmp_skip_pkg::op_skip_reg_bit_set)
					? src[bsel] : io[bsel];
				take = (c == (op == cmp_skip_pkg::op_skip_reg_bit_set || op == cmp_skip_pkg::op_skip_io_bit_set));
				mptr = mptr + (take ? (nlong ? 16'h0003 : 16'h0002) : 16'h0001);
				mbusy = take ? (nlong ? 2 : 1) : 0;
			end
			else
				mptr = mptr + 16'h0001;
		end
	endtask : apply

	// Watchdog against a hang
	initial
	begin
		#(8 * 6000);
		failures++;
		tally_and_finish();
	end

	// Main sequence
	initial
	begin
		repeat (5) @(negedge clk);
		check({6'h00, busy, flag_write, flag_register}, 16'h0000, "reset outputs");
		check(instruction_pointer, 16'h0000, "reset pointer");
		rst = 1'b0;
		mflags = 8'h00;
		mptr = 16'h0000;
		mbusy = 0;
		mwrite = 1'b0;
		for (int n = 0; n < 3000; n++)
		begin
			@(negedge clk);
			check({15'h0000, busy}, {15'h0000, mbusy != 0}, "busy");
			check({15'h0000, flag_write}, {15'h0000, mwrite}, "flag write");
			check({8'h00, flag_register}, {8'h00, mflags}, "flags");
			check(instruction_pointer, mptr, "pointer");
			if (n == 1500)
			begin
				// Mid-run reset, model restarted with it
				rst = 1'b1;
				issue = 1'b0;
				@(negedge clk);
				check({6'h00, busy, flag_write, flag_register}, 16'h0000, "mid-run reset outputs");
				check(instruction_pointer, 16'h0000, "mid-run reset pointer");
				rst = 1'b0;
				mflags = 8'h00;
				mptr = 16'h0000;
				mbusy = 0;
				mwrite = 1'b0;
				continue;
			end
			seed = lfsr_next(seed);
			{dest, src} = seed;
			seed = lfsr_next(seed);
			{imm, io} = seed;
			if (seed[3])
				src = dest;
			if (seed[4])
				imm = dest;
			seed = lfsr_next(seed);
			issue = seed[0] | seed[1];
			op = cmp_skip_pkg::op_t'(seed[4:2]);
			br = seed[5] & seed[6];
			bsel = seed[9:7];
			nlong = seed[10];
			ofs = {seed[15:11], seed[1:0]};
			apply();
		end
		tally_and_finish();
	end
endmodule : test_compare_skip_branch_exec
